/* File: pkg/c1io_map.svh */
`ifndef C1IO_MAP_SVH
`define C1IO_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets (low address byte only)
// ----------------------------------------------------------------------
`define C1IO_OFF_CTRL 8'h00
`define C1IO_OFF_STATUS 8'h04
`define C1IO_OFF_GEN_A 8'h08
`define C1IO_OFF_GEN_B 8'h0C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define C1IO_A_FIELD_LSB 0
`define C1IO_B_FIELD_LSB 4
`define C1IO_FIELD_W 4
`define C1IO_CAP_BIT 3
`define C1IO_SRC_BIT 2
`define C1IO_ST_PIN_LSB 0
`define C1IO_ST_CAP_LSB 2
`define C1IO_ST_CMP_LSB 4
`define C1IO_CTRL_RST 8'h00
`define C1IO_GEN_RST 16'h0000

`endif

/* File: pkg/c1io_pkg.sv */
package c1io_pkg;

   // ----------------------------------------------------------------------
   // Pin action on compare match
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ACT_HOLD = 2'b00,
      ACT_LOW = 2'b01,
      ACT_HIGH = 2'b10,
      ACT_TOGGLE = 2'b11
   } c1io_act_t;

   // ----------------------------------------------------------------------
   // Decoded behaviour of one mode field
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic capture;
      logic from_ch0;
      logic on_rise;
      logic on_fall;
      logic init_lvl;
      c1io_act_t act;
   } c1io_mode_t;

   // ----------------------------------------------------------------------
   // Bus request held from address phase into data phase
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } c1io_ahb_req_t;

endpackage

/* File: design/c1io_decode.sv */
`timescale 1ns/10ps
`include "c1io_map.svh"

module c1io_decode (
   // Four-bit mode field of one side
   input wire logic [3:0] field,
   // Decoded behaviour
   output c1io_pkg::c1io_mode_t mode
);

   // ----------------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------------
   wire logic cap = field[`C1IO_CAP_BIT];
   wire logic src = field[`C1IO_SRC_BIT];
   wire logic from_ch0 = cap & src;
   wire logic on_rise = cap & ~src & (field[1] | ~field[0]);
   wire logic on_fall = cap & ~src & (field[1] | field[0]);
   // Bit 2 of an output code picks the starting level
   wire logic init_lvl = ~cap & src;
   wire c1io_pkg::c1io_act_t act = cap ? c1io_pkg::ACT_HOLD :
                                  c1io_pkg::c1io_act_t'(field[1:0]);

   assign mode = '{capture: cap, from_ch0: from_ch0, on_rise: on_rise,
                   on_fall: on_fall, init_lvl: init_lvl, act: act};

endmodule // c1io_decode

/* File: design/c1io_edge.sv */
`timescale 1ns/10ps

module c1io_edge (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Sampled pin level
   input wire logic level,
   // Edge pulses, one cycle each
   output logic rise,
   output logic fall
);

   logic last_q;

   // ----------------------------------------------------------------------
   // Previous level
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_q <= 1'b0;
      end else begin
         last_q <= level;
      end
   end

   // Pin already synchronous, so no extra stages are spent here
   assign rise = level & ~last_q;
   assign fall = ~level & last_q;

endmodule // c1io_edge

/* File: design/c1io_top.sv */
// Summary of operation
// - Codes 0001 and 0101 start the pin at 0 and 1 and drive it low on each compare match.
// - Codes 0010 and 0110 start the pin at 0 and 1 and drive it high on each compare match.
// - Codes 0011 and 0111 start the pin at 0 and 1 and invert it on each compare match.
// - Code 1000 makes the register capture the counter on each rising pin edge.
// - Code 1001 makes the register capture the counter on each falling pin edge.
// - Codes 1010 and 1011 capture on both pin edges, the lowest field bit ignored.
// - Upper field 11xx captures into the B register on each channel 0 C event.
// - Lower field 11xx captures into the A register on each channel 0 A event.
`timescale 1ns/10ps
`include "c1io_map.svh"

module c1io_top #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Timer counter and channel 0 events
   input wire logic [CNT_W-1:0] counter_value,
   input wire logic counter_tick,
   input wire logic ch0_general_reg_a_event,
   input wire logic ch0_general_reg_c_event,
   // Channel 1 pins
   input wire logic ch1_pin_a_in,
   output logic ch1_pin_a_out,
   output logic ch1_pin_a_oe,
   input wire logic ch1_pin_b_in,
   output logic ch1_pin_b_out,
   output logic ch1_pin_b_oe,
   // General registers and event pulses
   output logic [CNT_W-1:0] ch1_general_reg_a,
   output logic [CNT_W-1:0] ch1_general_reg_b,
   output logic compare_match_a,
   output logic compare_match_b,
   output logic capture_a,
   output logic capture_b
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // Only the low address byte is decoded, so the map repeats every 256 bytes
   // Offsets are byte addresses of aligned words; partial accesses act as whole words
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      return addr == off;
   endfunction

   // Zero-extend a general register to a bus word
   // A counter wider than 32 bits would lose its top bits on reads
   function automatic logic [31:0] to_word(input logic [CNT_W-1:0] v);
      return 32'(v);
   endfunction

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   // Index 0 of every per-side array is the A side, index 1 the B side
   c1io_pkg::c1io_ahb_req_t req_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [CNT_W-1:0] gen_q [2];
   logic [CNT_W-1:0] gen_d [2];
   logic [1:0] pin_q;
   logic [1:0] pin_d;
   logic [1:0] oe_q;
   logic [1:0] cap_flag_q;
   logic [1:0] cap_flag_d;
   logic [1:0] cmp_flag_q;
   logic [1:0] cmp_flag_d;
   logic [1:0] match_pulse_q;
   logic [1:0] cap_pulse_q;
   logic [1:0] pin_in;
   logic [1:0] ch0_evt;
   logic [1:0] cmp_evt;
   logic [1:0] cap_evt;
   logic [1:0] wr_gen;
   c1io_pkg::c1io_mode_t mode_cur [2];
   c1io_pkg::c1io_mode_t mode_new [2];

   // ----------------------------------------------------------------------
   // Bus address phase
   // ----------------------------------------------------------------------

   // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready
   wire logic take = hsel & htrans[1] & hready;
   wire logic take_rd = take & ~hwrite;
   // An idle address phase clears the held request, so no stale strobe repeats
   wire c1io_pkg::c1io_ahb_req_t req_d = take ?
      c1io_pkg::c1io_ahb_req_t'{valid: 1'b1, write: hwrite, addr: haddr[7:0]} :
      c1io_pkg::c1io_ahb_req_t'('0);

   // Size is not checked; every access is treated as a whole word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_q <= '0;
      end else begin
         req_q <= req_d;
      end
   end

   // ----------------------------------------------------------------------
   // Bus data phase write strobes
   // ----------------------------------------------------------------------
   wire logic wr_phase = req_q.valid & req_q.write;
   wire logic wr_ctrl = wr_phase & hit(req_q.addr, `C1IO_OFF_CTRL);
   wire logic wr_status = wr_phase & hit(req_q.addr, `C1IO_OFF_STATUS);
   assign wr_gen[0] = wr_phase & hit(req_q.addr, `C1IO_OFF_GEN_A);
   assign wr_gen[1] = wr_phase & hit(req_q.addr, `C1IO_OFF_GEN_B);

   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------
   // Writes land at the end of the data phase, the only cycle hwdata is valid
   assign ctrl_d = wr_ctrl ? hwdata[7:0] : ctrl_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `C1IO_CTRL_RST;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // ----------------------------------------------------------------------
   // Field decode, current and incoming, per side
   // ----------------------------------------------------------------------

   // Side 0 is the A register and pin, side 1 the B register and pin
   c1io_decode u_dec_cur_a (
      .field(ctrl_q[`C1IO_A_FIELD_LSB +: `C1IO_FIELD_W]),
      .mode(mode_cur[0])
   );

   c1io_decode u_dec_cur_b (
      .field(ctrl_q[`C1IO_B_FIELD_LSB +: `C1IO_FIELD_W]),
      .mode(mode_cur[1])
   );

   // The incoming decode lets a write load the starting level at once
   c1io_decode u_dec_new_a (
      .field(ctrl_d[`C1IO_A_FIELD_LSB +: `C1IO_FIELD_W]),
      .mode(mode_new[0])
   );

   c1io_decode u_dec_new_b (
      .field(ctrl_d[`C1IO_B_FIELD_LSB +: `C1IO_FIELD_W]),
      .mode(mode_new[1])
   );

   // ----------------------------------------------------------------------
   // Per-side inputs
   // ----------------------------------------------------------------------
   // Pin inputs are taken as already in step with hclk
   assign pin_in[0] = ch1_pin_a_in;
   assign pin_in[1] = ch1_pin_b_in;
   // A side follows channel 0 A, B side follows channel 0 C
   assign ch0_evt[0] = ch0_general_reg_a_event;
   assign ch0_evt[1] = ch0_general_reg_c_event;

   // ----------------------------------------------------------------------
   // Per-side compare, capture and pin logic
   // ----------------------------------------------------------------------
   // Both sides share one body; the index picks register, pin and event source
   for (genvar s = 0; s < 2; s++) begin : g_side
      logic rise;
      logic fall;
      logic pin_edge;
      logic src_hit;

      // Edge history resets low, the pin idle level, so reset makes no false rise
      c1io_edge u_edge (
         .hclk(hclk),
         .hresetn(hresetn),
         .level(pin_in[s]),
         .rise(rise),
         .fall(fall)
      );

      // Pin edges as selected by the field
      assign pin_edge = (mode_cur[s].on_rise & rise) |
                        (mode_cur[s].on_fall & fall);
      assign src_hit = mode_cur[s].from_ch0 ? ch0_evt[s] : pin_edge;
      assign cap_evt[s] = mode_cur[s].capture & src_hit;

      // Match only counts on a counter step, so a stopped counter matches once
      // A capture field never compares, since the register then holds captures
      assign cmp_evt[s] = ~mode_cur[s].capture & counter_tick &
                          (counter_value == gen_q[s]);

      // Capture beats a software write to the same register
      assign gen_d[s] = cap_evt[s] ? counter_value :
                        wr_gen[s] ? hwdata[CNT_W-1:0] : gen_q[s];

      // Sticky flags: a new event wins over a write-one clear
      assign cap_flag_d[s] = cap_evt[s] |
         (cap_flag_q[s] & ~(wr_status & hwdata[`C1IO_ST_CAP_LSB + s]));
      assign cmp_flag_d[s] = cmp_evt[s] |
         (cmp_flag_q[s] & ~(wr_status & hwdata[`C1IO_ST_CMP_LSB + s]));

      // Pin level: a new output code loads its start level, else match acts
      // Start level wins over a match in the same cycle, so a retarget is not lost
      always_comb begin
         pin_d[s] = pin_q[s];
         if (wr_ctrl && !mode_new[s].capture &&
             mode_new[s].act != c1io_pkg::ACT_HOLD) begin
            pin_d[s] = mode_new[s].init_lvl;
         end else if (cmp_evt[s]) begin
            case (mode_cur[s].act)
               c1io_pkg::ACT_LOW: pin_d[s] = 1'b0;
               c1io_pkg::ACT_HIGH: pin_d[s] = 1'b1;
               c1io_pkg::ACT_TOGGLE: pin_d[s] = ~pin_q[s];
               default: pin_d[s] = pin_q[s];
            endcase
         end
      end

      // Side state
      // Output enable follows the incoming field, so the pin is released at the
      // same edge a capture code lands and never fights an outside driver
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            gen_q[s] <= CNT_W'(`C1IO_GEN_RST);
            pin_q[s] <= 1'b0;
            oe_q[s] <= 1'b1;
            cap_flag_q[s] <= 1'b0;
            cmp_flag_q[s] <= 1'b0;
            match_pulse_q[s] <= 1'b0;
            cap_pulse_q[s] <= 1'b0;
         end else begin
            gen_q[s] <= gen_d[s];
            pin_q[s] <= pin_d[s];
            oe_q[s] <= ~mode_new[s].capture;
            cap_flag_q[s] <= cap_flag_d[s];
            cmp_flag_q[s] <= cmp_flag_d[s];
            match_pulse_q[s] <= cmp_evt[s];
            cap_pulse_q[s] <= cap_evt[s];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------

   // Reads use next-state values so a write or capture just before is seen
   // Status layout: pins at bits 1..0, capture flags 3..2, match flags 5..4
   wire logic [31:0] status_word = 32'({cmp_flag_d, cap_flag_d, pin_d});
   wire logic [31:0] rd_word =
      hit(haddr[7:0], `C1IO_OFF_CTRL) ? 32'(ctrl_d) :
      hit(haddr[7:0], `C1IO_OFF_STATUS) ? status_word :
      hit(haddr[7:0], `C1IO_OFF_GEN_A) ? to_word(gen_d[0]) :
      hit(haddr[7:0], `C1IO_OFF_GEN_B) ? to_word(gen_d[1]) :
      32'h0000_0000;

   // Zero wait states, always OKAY
   // Ready is low only in reset, which keeps the master off the bus until then
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b0;
         hresp_q <= 1'b0;
      end else begin
         hrdata_q <= take_rd ? rd_word : hrdata_q;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, all from flip-flops
   // ----------------------------------------------------------------------
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign ch1_pin_a_out = pin_q[0];
   assign ch1_pin_a_oe = oe_q[0];
   assign ch1_pin_b_out = pin_q[1];
   assign ch1_pin_b_oe = oe_q[1];
   assign ch1_general_reg_a = gen_q[0];
   assign ch1_general_reg_b = gen_q[1];
   assign compare_match_a = match_pulse_q[0];
   assign compare_match_b = match_pulse_q[1];
   assign capture_a = cap_pulse_q[0];
   assign capture_b = cap_pulse_q[1];

endmodule // c1io_top

/* File: bench/c1io_checker.sv */
`timescale 1ns/10ps

module c1io_checker #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // Timer and channel 0 events
   input wire logic [CNT_W-1:0] counter_value,
   input wire logic counter_tick,
   input wire logic ch0_general_reg_a_event,
   input wire logic ch0_general_reg_c_event,
   // Channel 1 pins, registers and pulses
   input wire logic ch1_pin_a_in,
   input wire logic ch1_pin_b_in,
   input wire logic ch1_pin_a_oe,
   input wire logic ch1_pin_b_oe,
   input wire logic [CNT_W-1:0] ch1_general_reg_a,
   input wire logic [CNT_W-1:0] ch1_general_reg_b,
   input wire logic compare_match_a,
   input wire logic compare_match_b,
   input wire logic capture_a,
   input wire logic capture_b
);
   // ------------------
   // Temporal checks
   // ------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // A driven pin means output mode, so an equal count on a tick must match
   match_a_a:
      assert property (ch1_pin_a_oe && counter_tick && counter_value == ch1_general_reg_a
         |=> compare_match_a) else $error("compare a missed");
   match_b_a:
      assert property (ch1_pin_b_oe && counter_tick && counter_value == ch1_general_reg_b
         |=> compare_match_b) else $error("compare b missed");
   cap_nomatch_a:
      assert property (!ch1_pin_a_oe |=> !compare_match_a) else $error("match in capture");
   cap_val_a:
      assert property (capture_a |-> ch1_general_reg_a == $past(counter_value))
         else $error("capture a value");
   cap_val_b:
      assert property (capture_b |-> ch1_general_reg_b == $past(counter_value))
         else $error("capture b value");
   // A capture needs capture mode and either a pin change or the chosen event
   cause_a_a:
      assert property (capture_a |-> !$past(ch1_pin_a_oe) && ($past(ch0_general_reg_a_event)
         || $past(ch1_pin_a_in) != $past(ch1_pin_a_in, 2))) else $error("capture a cause");
   cause_b_a:
      assert property (capture_b |-> !$past(ch1_pin_b_oe) && ($past(ch0_general_reg_c_event)
         || $past(ch1_pin_b_in) != $past(ch1_pin_b_in, 2))) else $error("capture b cause");
   okay_resp_a:
      assert property (hresp == 1'h0) else $error("error response");
   zero_wait_a:
      assert property ($past(hresetn) |-> hreadyout) else $error("wait state");
endmodule // c1io_checker

bind c1io_top c1io_checker #(.CNT_W(CNT_W)) c1io_checker_inst (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .counter_value(counter_value), .counter_tick(counter_tick),
   .ch0_general_reg_a_event(ch0_general_reg_a_event),
   .ch0_general_reg_c_event(ch0_general_reg_c_event),
   .ch1_pin_a_in(ch1_pin_a_in), .ch1_pin_b_in(ch1_pin_b_in),
   .ch1_pin_a_oe(ch1_pin_a_oe), .ch1_pin_b_oe(ch1_pin_b_oe),
   .ch1_general_reg_a(ch1_general_reg_a), .ch1_general_reg_b(ch1_general_reg_b),
   .compare_match_a(compare_match_a), .compare_match_b(compare_match_b),
   .capture_a(capture_a), .capture_b(capture_b)
);

/* File: bench/c1io_tb_top.sv */
`timescale 1ns/10ps
`include "c1io_map.svh"

module c1io_tb_top;
   // ------------------
   // Stimulus and observation
   // ------------------
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic [15:0] cnt = 16'h0010;
   logic tick = 1'h0;
   logic ev_a = 1'h0;
   logic ev_c = 1'h0;
   logic pin_a = 1'h0;
   logic pin_b = 1'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, out_a, oe_a, out_b, oe_b, cm_a, cm_b, cap_a, cap_b;
   logic [15:0] gen_a, gen_b;
   logic [15:0] ga = 16'h0010;
   logic [15:0] gb = 16'h0010;
   logic ea = 1'h0;
   logic eb = 1'h0;
   logic [3:0] c, cb;
   logic [3:0] codes [6] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};
   int mismatches = 0;
   int checks_done = 0;

   // 125 MHz clock
   always #4 hclk = ~hclk;

   c1io_top c1io_top_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .counter_value(cnt), .counter_tick(tick),
      .ch0_general_reg_a_event(ev_a), .ch0_general_reg_c_event(ev_c),
      .ch1_pin_a_in(pin_a), .ch1_pin_a_out(out_a), .ch1_pin_a_oe(oe_a),
      .ch1_pin_b_in(pin_b), .ch1_pin_b_out(out_b), .ch1_pin_b_oe(oe_b),
      .ch1_general_reg_a(gen_a), .ch1_general_reg_b(gen_b),
      .compare_match_a(cm_a), .compare_match_b(cm_b), .capture_a(cap_a), .capture_b(cap_b)
   );

   // ------------------
   // Helpers
   // ------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task tally_and_finish;
      if (mismatches == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One single AHB transfer; read data is taken as the data phase ends
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      rd = hrdata;
   endtask

   // Pin level after a compare match, by the action bits of a field
   function automatic logic nxt(input logic [3:0] f, input logic cur);
      case (f[1:0])
         2'h0: nxt = cur;
         2'h1: nxt = 1'h0;
         2'h2: nxt = 1'h1;
         default: nxt = ~cur;
      endcase
   endfunction

   // Kind 0 rise, 1 fall, 2 channel 0 A event, 3 channel 0 C event
   task fire(input logic [1:0] k, input logic [3:0] f);
      logic ph, ha, hb;
      ph = (k == 2'h0) ? (f == 4'h8 || f[3:1] == 3'h5) :
           (k == 2'h1) ? (f == 4'h9 || f[3:1] == 3'h5) : 1'h0;
      ha = ph || (f[3:2] == 2'h3 && k == 2'h2);
      hb = ph || (f[3:2] == 2'h3 && k == 2'h3);
      cnt <= cnt + 16'h0011;
      if (k < 2'h2) begin
         pin_a <= ~k[0];
         pin_b <= ~k[0];
      end
      ev_a <= (k == 2'h2);
      ev_c <= (k == 2'h3);
      @(posedge hclk);
      ev_a <= 1'h0;
      ev_c <= 1'h0;
      @(posedge hclk);
      if (ha) ga = cnt;
      if (hb) gb = cnt;
      check(cap_a, ha);
      check(cap_b, hb);
      check(gen_a, ga);
      check(gen_b, gb);
   endtask

   // ------------------
   // Sequence
   // ------------------
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      ahb(1'h0, `C1IO_OFF_CTRL, 32'h0);
      check(rd, 32'h0);
      check({out_a, oe_a}, 2'h1);
      ahb(1'h1, `C1IO_OFF_GEN_A, 32'h10);
      ahb(1'h1, `C1IO_OFF_GEN_B, 32'h10);
      ahb(1'h1, 8'h10, 32'hFF);
      ahb(1'h0, 8'h10, 32'h0);
      check(rd, 32'h0);
      // Every output code on A, its opposite start level on B
      for (int i = 0; i < 8; i++) begin
         c = i[3:0];
         cb = c ^ 4'h4;
         ahb(1'h1, `C1IO_OFF_CTRL, {24'h0, cb, c});
         ahb(1'h0, `C1IO_OFF_CTRL, 32'h0);
         check(rd, {24'h0, cb, c});
         if (c[1:0] != 2'h0) ea = c[2];
         if (cb[1:0] != 2'h0) eb = cb[2];
         check({out_b, out_a}, {eb, ea});
         tick <= 1'h1;
         @(posedge hclk);
         tick <= 1'h0;
         @(posedge hclk);
         ea = nxt(c, ea);
         eb = nxt(cb, eb);
         check({cm_b, cm_a, oe_b, oe_a}, 4'hF);
         check({out_b, out_a}, {eb, ea});
      end
      ahb(1'h0, `C1IO_OFF_STATUS, 32'h0);
      check(rd, {26'h0, 4'hC, eb, ea});
      ahb(1'h1, `C1IO_OFF_STATUS, 32'h3C);
      ahb(1'h0, `C1IO_OFF_STATUS, 32'h0);
      check(rd, {30'h0, eb, ea});
      // Capture codes 8, 9, A, B, C and F on both sides, against every trigger
      for (int i = 0; i < 6; i++) begin
         ahb(1'h1, `C1IO_OFF_CTRL, {24'h0, codes[i], codes[i]});
         // An equal count on a tick must not match once the field captures
         cnt <= ga;
         tick <= 1'h1;
         @(posedge hclk);
         tick <= 1'h0;
         @(posedge hclk);
         check({cm_b, cm_a, oe_b, oe_a}, 4'h0);
         for (int k = 0; k < 4; k++) begin
            fire(k[1:0], codes[i]);
         end
      end
      tally_and_finish;
   end

   // Hang guard, well beyond the roughly 150 cycles the sequence needs
   initial begin
      repeat (5000) @(posedge hclk);
      mismatches++;
      tally_and_finish;
   end
endmodule // c1io_tb_top
